// ### rtl/bmd_walker.sv
// two-channel bus-master descriptor table walker
`timescale 1ns/1ns
`include "bmd_regs.svh"
// How it works
// - pointer register holds bits 31 to 2 of the table start address
// - pointer bits 1 and 0 ignore writes and read as zero
// - each descriptor is two dwords, four bytes apart, so descriptors sit eight bytes apart
// - region address is dword 0 bits 31 to 1, bit 0 forced zero
// - exactly the low sixteen bits of dword 1 give the byte count
// - a zero byte count means 64K bytes
// - dword 1 bit 31 marks the last descriptor
// - operation ends after the marked descriptor, nothing further fetched
// - processing begins at the pointer address on start
// - run bit one starts, zero aborts for good
// - command bit 3 selects direction, one is drive to memory
// - active bit set on start, cleared on abort or normal end
// - registers locked until base address register 4 is nonzero
module bmd_walker
  import bmd_pkg::*;
(
  // clock and reset
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  // configuration
  input wire logic bar4_set_in,
  // io register port
  input wire logic io_rd_in,
  input wire logic io_wr_in,
  input wire logic [3:0] io_addr_in,
  input wire logic [3:0] io_be_in,
  input wire logic [31:0] io_wdata_in,
  output logic [31:0] io_rdata_out,
  output logic io_rvalid_out,
  // memory master, one per channel
  output logic [1:0] mem_req_out,
  output logic [1:0] mem_we_out,
  output logic [1:0][31:0] mem_addr_out,
  output logic [1:0][3:0] mem_be_out,
  output logic [1:0][31:0] mem_wdata_out,
  input wire logic [1:0] mem_ack_in,
  input wire logic [1:0][31:0] mem_rdata_in,
  // drive data, one per channel
  output logic [1:0] drv_tx_valid_out,
  output logic [1:0][15:0] drv_tx_data_out,
  input wire logic [1:0] drv_tx_ready_in,
  input wire logic [1:0] drv_rx_valid_in,
  input wire logic [1:0][15:0] drv_rx_data_in,
  output logic [1:0] drv_rx_ready_out,
  // status
  output logic [1:0] act_out
);

  bmd_top_s st_q;
  bmd_top_s st_d;
  logic [1:0] step_w;
  logic [1:0] start_w;
  logic [1:0] abort_w;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    logic [3:0] cmd_ofs;
    logic [3:0] ptr_ofs;
    logic cmd_wr;
    logic ptr_wr;
    cmd_ofs = `BMD_OFS_PRI_CMD;
    ptr_ofs = `BMD_OFS_PRI_PTR;
    cmd_wr = 1'b0;
    ptr_wr = 1'b0;
    st_d = st_q;
    step_w = 2'b00;
    start_w = 2'b00;
    abort_w = 2'b00;
    st_d.rvalid = io_rd_in;
    st_d.rdata = `BMD_RST_WORD;
    for (int c = 0; c < 2; c++)
    begin
      cmd_ofs = (c == 0) ? `BMD_OFS_PRI_CMD : `BMD_OFS_SEC_CMD;
      ptr_ofs = (c == 0) ? `BMD_OFS_PRI_PTR : `BMD_OFS_SEC_PTR;
      cmd_wr = io_wr_in && bar4_set_in && (io_addr_in == cmd_ofs);
      ptr_wr = io_wr_in && bar4_set_in && (io_addr_in == ptr_ofs);
      // register reads
      if (io_rd_in && bar4_set_in && (io_addr_in == cmd_ofs))
      begin
        st_d.rdata[`BMD_CMD_RUN] = st_q.ch[c].run;
        st_d.rdata[`BMD_CMD_DIR] = st_q.ch[c].dir;
        st_d.rdata[`BMD_STS_ACT] = st_q.ch[c].act;
        st_d.rdata[`BMD_STS_MDC] = st_q.ch[c].mdc;
        st_d.rdata[`BMD_STS_SDC] = st_q.ch[c].sdc;
      end
      if (io_rd_in && bar4_set_in && (io_addr_in == ptr_ofs))
      begin
        st_d.rdata = {st_q.ch[c].tbl, 2'b00};
      end
      // descriptor walk
      unique case (st_q.ch[c].state)
        st_idle:
        begin
          st_d.ch[c].mreq = 1'b0;
        end
        st_fetch0:
        begin
          if (!st_q.ch[c].mreq)
          begin
            st_d.ch[c].mreq = 1'b1;
            st_d.ch[c].mwe = 1'b0;
            st_d.ch[c].madr = st_q.ch[c].dptr;
            st_d.ch[c].mbe = 4'hf;
          end
          else if (mem_ack_in[c])
          begin
            st_d.ch[c].mreq = 1'b0;
            st_d.ch[c].radr = {mem_rdata_in[c][31:1], 1'b0};
            st_d.ch[c].dptr = st_q.ch[c].dptr + `BMD_DWORD_STEP;
            st_d.ch[c].state = st_fetch1;
          end
        end
        st_fetch1:
        begin
          if (!st_q.ch[c].mreq)
          begin
            st_d.ch[c].mreq = 1'b1;
            st_d.ch[c].mwe = 1'b0;
            st_d.ch[c].madr = st_q.ch[c].dptr;
            st_d.ch[c].mbe = 4'hf;
          end
          else if (mem_ack_in[c])
          begin
            st_d.ch[c].mreq = 1'b0;
            // bits 30 to 16 are not looked at
            st_d.ch[c].cnt = {1'b0, mem_rdata_in[c][15:0]};
            if (mem_rdata_in[c][15:0] == 16'h0000)
            begin
              st_d.ch[c].cnt = `BMD_CNT_MAX;
            end
            st_d.ch[c].end_of_table_flag = mem_rdata_in[c][`BMD_DESC_EOT];
            st_d.ch[c].dptr = st_q.ch[c].dptr + `BMD_DWORD_STEP;
            st_d.ch[c].state = st_q.ch[c].dir ? st_drive : st_move;
          end
        end
        st_move:
        begin
          if (!st_q.ch[c].mreq)
          begin
            st_d.ch[c].mreq = 1'b1;
            st_d.ch[c].mwe = st_q.ch[c].dir;
            st_d.ch[c].madr = {st_q.ch[c].radr[31:2], 2'b00};
            st_d.ch[c].mbe = st_q.ch[c].radr[1] ? 4'hc : 4'h3;
            st_d.ch[c].mwd = {st_q.ch[c].hw, st_q.ch[c].hw};
          end
          else if (mem_ack_in[c])
          begin
            st_d.ch[c].mreq = 1'b0;
            if (st_q.ch[c].dir)
            begin
              step_w[c] = 1'b1;
            end
            else
            begin
              st_d.ch[c].hw = st_q.ch[c].radr[1] ?
                mem_rdata_in[c][31:16] : mem_rdata_in[c][15:0];
              st_d.ch[c].txv = 1'b1;
              st_d.ch[c].state = st_drive;
            end
          end
        end
        st_drive:
        begin
          if (st_q.ch[c].dir)
          begin
            st_d.ch[c].rxr = 1'b1;
            if (st_q.ch[c].rxr && drv_rx_valid_in[c])
            begin
              st_d.ch[c].rxr = 1'b0;
              st_d.ch[c].hw = drv_rx_data_in[c];
              st_d.ch[c].state = st_move;
            end
          end
          else if (st_q.ch[c].txv && drv_tx_ready_in[c])
          begin
            st_d.ch[c].txv = 1'b0;
            step_w[c] = 1'b1;
          end
        end
        default:
        begin
          st_d.ch[c].state = st_idle;
          st_d.ch[c].act = 1'b0;
        end
      endcase
      // one halfword moved
      if (step_w[c])
      begin
        st_d.ch[c].radr = st_q.ch[c].radr + `BMD_HALF_STEP;
        st_d.ch[c].cnt = 17'(st_q.ch[c].cnt - `BMD_CNT_LAST);
        if (st_q.ch[c].cnt == `BMD_CNT_LAST)
        begin
          if (st_q.ch[c].end_of_table_flag)
          begin
            st_d.ch[c].state = st_idle;
            st_d.ch[c].act = 1'b0;
          end
          else
          begin
            st_d.ch[c].state = st_fetch0;
          end
        end
        else
        begin
          st_d.ch[c].state = st_q.ch[c].dir ? st_drive : st_move;
        end
      end
      // command and status writes
      if (cmd_wr && io_be_in[0])
      begin
        st_d.ch[c].run = io_wdata_in[`BMD_CMD_RUN];
        st_d.ch[c].dir = io_wdata_in[`BMD_CMD_DIR];
        start_w[c] = io_wdata_in[`BMD_CMD_RUN] && !st_q.ch[c].act;
        abort_w[c] = !io_wdata_in[`BMD_CMD_RUN] && st_q.ch[c].act;
      end
      if (cmd_wr && io_be_in[2])
      begin
        st_d.ch[c].mdc = io_wdata_in[`BMD_STS_MDC];
        st_d.ch[c].sdc = io_wdata_in[`BMD_STS_SDC];
      end
      if (start_w[c])
      begin
        st_d.ch[c].act = 1'b1;
        st_d.ch[c].state = st_fetch0;
        st_d.ch[c].dptr = {st_q.ch[c].tbl, 2'b00};
        st_d.ch[c].mreq = 1'b0;
        st_d.ch[c].txv = 1'b0;
        st_d.ch[c].rxr = 1'b0;
      end
      if (abort_w[c])
      begin
        st_d.ch[c].act = 1'b0;
        st_d.ch[c].state = st_idle;
        st_d.ch[c].mreq = 1'b0;
        st_d.ch[c].txv = 1'b0;
        st_d.ch[c].rxr = 1'b0;
      end
      // pointer write by byte lane, low two bits dropped
      if (ptr_wr && io_be_in[0])
      begin
        st_d.ch[c].tbl[5:0] = io_wdata_in[7:2];
      end
      if (ptr_wr && io_be_in[1])
      begin
        st_d.ch[c].tbl[13:6] = io_wdata_in[15:8];
      end
      if (ptr_wr && io_be_in[2])
      begin
        st_d.ch[c].tbl[21:14] = io_wdata_in[23:16];
      end
      if (ptr_wr && io_be_in[3])
      begin
        st_d.ch[c].tbl[29:22] = io_wdata_in[31:24];
      end
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      st_q <= '0;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  assign io_rdata_out = st_q.rdata;
  assign io_rvalid_out = st_q.rvalid;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (!rst_n_in);

  ptr_low_zero_a: assert property (
    (io_rd_in && io_addr_in[2]) |=> (io_rdata_out[1:0] == 2'b00))
    else $error("pointer low bits not zero");

  locked_read_a: assert property (
    (io_rd_in && !bar4_set_in) |=> (io_rdata_out == 32'h0))
    else $error("locked register read returned data");

  // ----------------------------------------------------------------
  // per-channel outputs and checks
  // ----------------------------------------------------------------
  for (genvar g = 0; g < 2; g++)
  begin : gen_chan
    assign mem_req_out[g] = st_q.ch[g].mreq;
    assign mem_we_out[g] = st_q.ch[g].mwe;
    assign mem_addr_out[g] = st_q.ch[g].madr;
    assign mem_be_out[g] = st_q.ch[g].mbe;
    assign mem_wdata_out[g] = st_q.ch[g].mwd;
    assign drv_tx_valid_out[g] = st_q.ch[g].txv;
    assign drv_tx_data_out[g] = st_q.ch[g].hw;
    assign drv_rx_ready_out[g] = st_q.ch[g].rxr;
    assign act_out[g] = st_q.ch[g].act;

    ptr_write_a: assert property (
      (io_wr_in && bar4_set_in && io_be_in == 4'hf &&
       io_addr_in == ((g == 0) ? `BMD_OFS_PRI_PTR : `BMD_OFS_SEC_PTR))
      |=> (st_q.ch[g].tbl == $past(io_wdata_in[31:2])))
      else $error("pointer write not stored");

    desc_step_a: assert property (
      (st_q.ch[g].state == st_fetch1 && st_q.ch[g].mreq &&
       mem_ack_in[g] && !start_w[g])
      |=> (st_q.ch[g].dptr == $past(st_q.ch[g].madr) + `BMD_DWORD_STEP))
      else $error("descriptor pointer step wrong");

    base_align_a: assert property (
      (st_q.ch[g].state == st_fetch0 && st_q.ch[g].mreq &&
       mem_ack_in[g] && !start_w[g] && !abort_w[g])
      |=> (st_q.ch[g].radr == {$past(mem_rdata_in[g][31:1]), 1'b0}))
      else $error("region address wrong");

    count_load_a: assert property (
      (st_q.ch[g].state == st_fetch1 && st_q.ch[g].mreq &&
       mem_ack_in[g] && mem_rdata_in[g][15:0] != 16'h0 &&
       !start_w[g] && !abort_w[g])
      |=> (st_q.ch[g].cnt == {1'b0, $past(mem_rdata_in[g][15:0])}))
      else $error("byte count wrong");

    zero_count_a: assert property (
      (st_q.ch[g].state == st_fetch1 && st_q.ch[g].mreq &&
       mem_ack_in[g] && mem_rdata_in[g][15:0] == 16'h0 &&
       !start_w[g] && !abort_w[g])
      |=> (st_q.ch[g].cnt == `BMD_CNT_MAX))
      else $error("zero count not 64K");

    eot_flag_a: assert property (
      (st_q.ch[g].state == st_fetch1 && st_q.ch[g].mreq &&
       mem_ack_in[g] && !start_w[g] && !abort_w[g])
      |=> (st_q.ch[g].end_of_table_flag == $past(mem_rdata_in[g][31])))
      else $error("end flag not captured");

    eot_end_a: assert property (
      (step_w[g] && st_q.ch[g].cnt == `BMD_CNT_LAST && st_q.ch[g].end_of_table_flag &&
       !start_w[g]) |=> (st_q.ch[g].state == st_idle && !st_q.ch[g].act)
      ##1 !st_q.ch[g].mreq)
      else $error("walk did not end after marked descriptor");

    next_fetch_a: assert property (
      (step_w[g] && st_q.ch[g].cnt == `BMD_CNT_LAST && !st_q.ch[g].end_of_table_flag &&
       !start_w[g] && !abort_w[g] && !io_wr_in)
      |=> (st_q.ch[g].state == st_fetch0)
      ##1 ($past(abort_w[g]) || (st_q.ch[g].mreq &&
           st_q.ch[g].madr == $past(st_q.ch[g].dptr))))
      else $error("next descriptor not fetched");

    start_a: assert property (
      start_w[g] |=> (st_q.ch[g].state == st_fetch0 && st_q.ch[g].act &&
        st_q.ch[g].dptr == {$past(st_q.ch[g].tbl), 2'b00}))
      else $error("start did not begin at table pointer");

    abort_a: assert property (
      abort_w[g] |=> (st_q.ch[g].state == st_idle && !st_q.ch[g].act &&
        !st_q.ch[g].mreq))
      else $error("abort did not stop the channel");

    dir_a: assert property (
      (st_q.ch[g].state == st_move && st_q.ch[g].mreq)
      |-> (st_q.ch[g].mwe == st_q.ch[g].dir))
      else $error("memory direction wrong");

    start_c: cover property (start_w[g]);
    normal_end_c: cover property (
      step_w[g] && st_q.ch[g].cnt == `BMD_CNT_LAST && st_q.ch[g].end_of_table_flag);
    chain_c: cover property (
      step_w[g] && st_q.ch[g].cnt == `BMD_CNT_LAST && !st_q.ch[g].end_of_table_flag);
    to_mem_c: cover property (step_w[g] && st_q.ch[g].dir);
  end

endmodule : bmd_walker

// ### shared/bmd_pkg.sv
// types of the descriptor walker
package bmd_pkg;

  typedef enum logic [2:0] {
    st_idle = 3'h0,
    st_fetch0 = 3'h1,
    st_fetch1 = 3'h3,
    st_move = 3'h2,
    st_drive = 3'h6
  } bmd_state_e;

  typedef struct packed {
    bmd_state_e state;
    logic run;
    logic dir;
    logic act;
    logic mdc;
    logic sdc;
    logic [29:0] tbl;
    logic [31:0] dptr;
    logic [31:0] radr;
    logic [16:0] cnt;
    logic end_of_table_flag;
    logic mreq;
    logic mwe;
    logic [31:0] madr;
    logic [3:0] mbe;
    logic [31:0] mwd;
    logic [15:0] hw;
    logic txv;
    logic rxr;
  } bmd_chan_s;

  typedef struct packed {
    bmd_chan_s [1:0] ch;
    logic [31:0] rdata;
    logic rvalid;
  } bmd_top_s;

endpackage : bmd_pkg

// ### shared/bmd_regs.svh
// register offsets, field positions and steps of the descriptor walker
`ifndef BMD_REGS_SVH
`define BMD_REGS_SVH

// io register byte offsets from the base address
`define BMD_OFS_PRI_CMD 4'h0
`define BMD_OFS_PRI_PTR 4'h4
`define BMD_OFS_SEC_CMD 4'h8
`define BMD_OFS_SEC_PTR 4'hc

// command byte (lane 0) and status byte (lane 2) bit positions
`define BMD_CMD_RUN 0
`define BMD_CMD_DIR 3
`define BMD_STS_ACT 16
`define BMD_STS_MDC 21
`define BMD_STS_SDC 22

// descriptor fields
`define BMD_DESC_EOT 31
`define BMD_DWORD_STEP 32'h4
`define BMD_HALF_STEP 32'h2
`define BMD_CNT_MAX 17'h10000
`define BMD_CNT_LAST 17'h00002

// reset values
`define BMD_RST_WORD 32'h0

`endif

// ### test/bmd_mem_model.sv
// memory target model answering both channel masters
`timescale 1ns/1ns
module bmd_mem_model
  import bmd_pkg::*;
(
  // clock and reset
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  // master requests
  input wire logic [1:0] req_in,
  input wire logic [1:0] we_in,
  input wire logic [1:0][31:0] addr_in,
  input wire logic [1:0][3:0] be_in,
  input wire logic [1:0][31:0] wdata_in,
  input wire logic [3:0] lat_in,
  // answers
  output logic [1:0] ack_out,
  output logic [1:0][31:0] rdata_out
);
  // ----------------
  // target behaviour
  // ----------------
  logic [31:0] mem [logic [31:0]];
  logic [1:0][31:0] rd_q;
  logic [1:0][3:0] wt_q;
  logic [31:0] w;
  // released data lines show the inverse of the last word
  assign rdata_out[0] = ack_out[0] ? rd_q[0] : ~rd_q[0];
  assign rdata_out[1] = ack_out[1] ? rd_q[1] : ~rd_q[1];
  always @(posedge ref_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      ack_out <= 2'h0;
      wt_q <= 8'h00;
      rd_q <= 64'h0;
    end
    else
    begin
      for (int c = 0; c < 2; c++)
      begin
        ack_out[c] <= 1'b0;
        wt_q[c] <= 4'h0;
        if (req_in[c] && !ack_out[c] && wt_q[c] < lat_in)
          wt_q[c] <= wt_q[c] + 4'h1;
        else if (req_in[c] && !ack_out[c])
        begin
          ack_out[c] <= 1'b1;
          w = mem.exists(addr_in[c]) ? mem[addr_in[c]] : 32'h0;
          for (int b = 0; b < 4; b++)
            if (we_in[c] && be_in[c][b])
              w[8 * b +: 8] = wdata_in[c][8 * b +: 8];
          mem[addr_in[c]] = w;
          rd_q[c] <= w;
        end
      end
    end
  end
endmodule : bmd_mem_model

// ### test/tb_ide_bus_master_descriptor_walk.sv
// self-checking bench for the descriptor table walker
`timescale 1ns/1ns
module tb_ide_bus_master_descriptor_walk;
  import bmd_pkg::*;
  logic ref_clk_in;
  logic rst_n_in;
  logic bar4_set_in;
  logic io_rd_in;
  logic io_wr_in;
  logic [3:0] io_addr_in;
  logic [3:0] io_be_in;
  logic [31:0] io_wdata_in;
  logic [31:0] io_rdata;
  logic io_rvalid;
  logic [1:0] req, we, ack, tx_v, tx_rdy, rx_v, rx_rdy, act;
  logic [1:0][31:0] adr, wd, rdat;
  logic [1:0][3:0] be;
  logic [1:0][15:0] tx_d, rx_d;
  logic [3:0] lat;
  logic cur;
  logic [31:0] rng = 32'h0000c589;
  logic [15:0] got_q [$];
  logic [15:0] rx_buf [$];
  int rx_i = 0;
  int n_fail = 0;
  int tests_run = 0;

  bmd_walker dut (
    .ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in),
    .bar4_set_in(bar4_set_in), .io_rd_in(io_rd_in),
    .io_wr_in(io_wr_in), .io_addr_in(io_addr_in), .io_be_in(io_be_in),
    .io_wdata_in(io_wdata_in), .io_rdata_out(io_rdata),
    .io_rvalid_out(io_rvalid), .mem_req_out(req), .mem_we_out(we),
    .mem_addr_out(adr), .mem_be_out(be), .mem_wdata_out(wd),
    .mem_ack_in(ack), .mem_rdata_in(rdat), .drv_tx_valid_out(tx_v),
    .drv_tx_data_out(tx_d), .drv_tx_ready_in(tx_rdy),
    .drv_rx_valid_in(rx_v), .drv_rx_data_in(rx_d),
    .drv_rx_ready_out(rx_rdy), .act_out(act)
  );
  bmd_mem_model mdl (
    .ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .req_in(req),
    .we_in(we), .addr_in(adr), .be_in(be), .wdata_in(wd),
    .lat_in(lat), .ack_out(ack), .rdata_out(rdat)
  );

  // ------------------
  // helpers and checks
  // ------------------
  function automatic logic [31:0] rnd();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction : rnd

  function automatic logic [15:0] half(input logic [31:0] a);
    logic [31:0] w;
    w = mdl.mem[{a[31:2], 2'h0}];
    return a[1] ? w[31:16] : w[15:0];
  endfunction : half

  task automatic chk_word(input logic [31:0] g, input logic [31:0] e,
    input string m);
    tests_run++;
    if (g !== e)
    begin
      n_fail++;
      $display("mismatch at %0t: %s got %h exp %h", $time, m, g, e);
    end
  endtask : chk_word

  task automatic chk_flag(input logic g, input logic e, input string m);
    tests_run++;
    if (g !== e)
    begin
      n_fail++;
      $display("mismatch at %0t: %s flag %b", $time, m, g);
    end
  endtask : chk_flag

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : end_of_test

  task automatic io_write(input logic [3:0] a, input logic [3:0] m,
    input logic [31:0] d);
    @(posedge ref_clk_in);
    io_wr_in <= 1'b1;
    io_addr_in <= a;
    io_be_in <= m;
    io_wdata_in <= d;
    @(posedge ref_clk_in);
    io_wr_in <= 1'b0;
    io_wdata_in <= ~d;
  endtask : io_write

  task automatic io_read(input logic [3:0] a, output logic [31:0] d);
    @(posedge ref_clk_in);
    io_rd_in <= 1'b1;
    io_addr_in <= a;
    @(posedge ref_clk_in);
    io_rd_in <= 1'b0;
    #1;
    d = io_rvalid === 1'b1 ? io_rdata : 32'hx;
  endtask : io_read

  task automatic walk(input logic c, input logic dir, input int nd,
    input logic zero);
    logic [31:0] tbl;
    logic [31:0] ra;
    logic [31:0] rd;
    logic [15:0] cnt;
    logic [31:0] adr_q [$];
    logic [15:0] exp_q [$];
    logic hung;
    int k;
    @(negedge ref_clk_in);
    cur = c;
    lat = 4'(rnd() % 4);
    got_q.delete();
    rx_buf.delete();
    rx_i = 0;
    tbl = {15'h0, c, 16'h0} + {16'h0001, 8'(rnd()), 8'h00};
    for (int i = 0; i < nd; i++)
    begin
      ra = {12'h002, c, 3'(i), 1'b0, 7'(rnd()), 7'(rnd()), 1'b0};
      cnt = zero ? 16'h0 : {11'h0, 4'(rnd()) | 4'h1, 1'b0};
      if (zero)
        ra[15:0] = 16'h0;
      mdl.mem[tbl + 8 * i] = ra | {31'h0, 1'(rnd())};
      mdl.mem[tbl + 8 * i + 4] = {i == nd - 1, 15'(rnd()), cnt};
      for (k = 0; k < (zero ? 300 : cnt / 2); k++)
      begin
        adr_q.push_back(ra + 2 * k);
        mdl.mem[(ra + 2 * k) & 32'hfffffffc] = rnd();
        rx_buf.push_back(16'(rnd()));
      end
    end
    foreach (adr_q[j])
      exp_q.push_back(dir ? rx_buf[j] : half(adr_q[j]));
    io_write({c, 3'h4}, 4'hf, tbl);
    io_write({c, 3'h0}, 4'h1, {28'h0, dir, 3'h1});
    io_read({c, 3'h0}, rd);
    chk_flag(rd[16], 1'b1, "active");
    for (k = 0; k < 20000 && act[c] === 1'b1; k++)
    begin
      if (zero && got_q.size() >= 300)
        break;
      @(negedge ref_clk_in);
    end
    if (zero)
    begin
      chk_flag(act[c], 1'b1, "long count");
      io_write({c, 3'h0}, 4'h1, 32'h0);
      @(negedge ref_clk_in);
    end
    else
      chk_word(dir ? rx_i : got_q.size(), exp_q.size(), "units");
    chk_flag(act[c], 1'b0, "ended");
    hung = 1'b0;
    repeat (20)
    begin
      @(negedge ref_clk_in);
      hung |= req[c] | tx_v[c] | rx_rdy[c];
    end
    chk_flag(hung, 1'b0, "quiet");
    foreach (exp_q[j])
      chk_word(dir ? half(adr_q[j]) : got_q[j], exp_q[j], "data");
  endtask : walk

  // ---------------
  // stimulus
  // ---------------
  always @(posedge ref_clk_in)
  begin : stream
    logic nv;
    if (!rst_n_in)
    begin
      rx_v <= 2'h0;
      rx_d <= 32'h0;
      tx_rdy <= 2'h0;
    end
    else
    begin
      if (tx_v[cur] && tx_rdy[cur])
        got_q.push_back(tx_d[cur]);
      nv = rx_v[cur] && !rx_rdy[cur];
      if (rx_v[cur] && rx_rdy[cur])
        rx_i++;
      if (!nv)
        nv = 1'(rnd()) && rx_i < rx_buf.size();
      rx_v <= nv ? 2'h1 << cur : 2'h0;
      rx_d <= {2{nv ? rx_buf[rx_i] : ~rx_d[cur]}};
      tx_rdy <= 1'(rnd()) ? 2'h1 << cur : 2'h0;
    end
  end

  initial
  begin
    ref_clk_in = 1'b0;
    forever #2 ref_clk_in = ~ref_clk_in;
  end

  initial
  begin
    repeat (60000) @(posedge ref_clk_in);
    n_fail++;
    end_of_test();
  end

  initial
  begin : main
    logic [31:0] rd;
    logic [31:0] w;
    rst_n_in = 1'b0;
    bar4_set_in = 1'b0;
    io_rd_in = 1'b0;
    io_wr_in = 1'b0;
    io_addr_in = 4'h0;
    io_be_in = 4'h0;
    io_wdata_in = 32'h0;
    lat = 4'h0;
    cur = 1'b0;
    repeat (2) @(posedge ref_clk_in);
    rst_n_in <= 1'b1;
    chk_word({30'h0, act}, 32'h0, "idle");
    io_write(4'h4, 4'hf, 32'hffffffff);
    bar4_set_in <= 1'b1;
    io_read(4'h4, rd);
    chk_word(rd, 32'h0, "locked");
    w = rnd();
    io_write(4'hc, 4'hf, w);
    io_read(4'hc, rd);
    chk_word(rd, w & 32'hfffffffc, "pointer");
    @(posedge ref_clk_in);
    bar4_set_in <= 1'b0;
    io_read(4'hc, rd);
    chk_word(rd, 32'h0, "locked read");
    @(posedge ref_clk_in);
    bar4_set_in <= 1'b1;
    io_read(4'h1, rd);
    chk_word(rd, 32'h0, "unmapped");
    for (int i = 0; i < 8; i++)
      walk(i[0], i[1], i == 5 ? 1 : 1 + i % 3, i == 5);
    end_of_test();
  end
endmodule : tb_ide_bus_master_descriptor_walk
